//--- logic/slmi_defs.svh
// constants for the serial lane map and polarity invert register bank
// assumes inclusion by the package, the design file and the bench only
`ifndef SLMI_DEFS_SVH
`define SLMI_DEFS_SVH

// register indices; byte address is four times the index
`define SLMI_IDX_MAP_MID   12'h5b5
`define SLMI_IDX_MAP_UP    12'h5b6
`define SLMI_IDX_INVERT    12'h5bf

// reset values
`define SLMI_RST_MAP_MID   8'h54
`define SLMI_RST_MAP_UP    8'h76
`define SLMI_RST_INVERT    8'h00

// writable bits of a map register
`define SLMI_MAP_MASK      8'h77

// field layout of a map register
`define SLMI_F_LO_LSB      0
`define SLMI_F_HI_LSB      4
`define SLMI_F_W           3

// first invert bit served here (physical lane 4)
`define SLMI_INV_BASE      4
`define SLMI_PHYS_BASE     4

// bus widths and answers
`define SLMI_ADDR_W        16
`define SLMI_IDX_W         12
`define SLMI_RESP_OKAY     2'h0
`define SLMI_RESP_DECERR   2'h3

// stream defaults
`define SLMI_LOG_LANES     8
`define SLMI_PHYS_LANES    4
`define SLMI_LANE_W_DEF    8
`define SLMI_FIFO_D_DEF    4

`endif

//--- logic/slmi_pkg.sv
// types shared by the serial lane map block
// assumes slmi_defs.svh sits on the include path
`include "slmi_defs.svh"

package slmi_pkg;

    // software visible registers
    typedef struct packed {
        logic [7:0] lane_map_middle_pair;
        logic [7:0] lane_map_upper_pair;
        logic [7:0] lane_polarity_invert;
    } slmi_regs_t;

    // bus slave bookkeeping
    typedef struct packed {
        logic                   aw_have;
        logic [`SLMI_IDX_W-1:0] aw_idx;
        logic                   w_have;
        logic [7:0]             w_byte;
        logic                   w_strb0;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [7:0]             rbyte;
        logic                   r_is_map;
    } slmi_bus_t;

endpackage : slmi_pkg

//--- logic/slmi_top.sv
// lane FIFO and the lane map / polarity invert block with its AXI4-Lite slave
// assumes one clock, asynchronous active-low reset, and a clock enable
`timescale 1ns/1ps
`include "slmi_defs.svh"

// small synchronous FIFO with valid/ready on both sides
module slmi_fifo import slmi_pkg::*; #(
    parameter int W     = 64,
    parameter int DEPTH = `SLMI_FIFO_D_DEF
) (
    input  wire logic         clk_sys,   // system clock
    input  wire logic         rst_b,     // async reset, low active
    input  wire logic         ce,        // clock enable, freezes state
    input  wire logic         in_valid,  // producer offers a word
    output logic              in_ready,  // room for a word
    input  wire logic [W-1:0] in_data,   // word in
    output logic              out_valid, // word waiting
    input  wire logic         out_ready, // consumer takes it
    output logic [W-1:0]      out_data   // oldest word
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // elaboration check: pointers wrap naturally only on powers of two
    if (DEPTH < 2 || (1 << PW) != DEPTH || W < 1) begin : g_bad
        $error("slmi_fifo: DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } slmi_fifo_st_t;

    slmi_fifo_st_t q;
    slmi_fifo_st_t d;
    logic          push;
    logic          pop;

    // honest full and empty, gated by the enable
    assign in_ready  = ce && (q.cnt != CW'(DEPTH));
    assign out_valid = ce && (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // next state
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = q.wp + PW'(1);
        end
        if (pop) begin
            d.rp = q.rp + PW'(1);
        end
        if (push && !pop) begin
            d.cnt = q.cnt + CW'(1);
        end else if (pop && !push) begin
            d.cnt = q.cnt - CW'(1);
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule : slmi_fifo

// maps logical lanes onto physical lanes 4..7 and inverts them on request
module slmi_top import slmi_pkg::*; #(
    parameter int LANE_W     = `SLMI_LANE_W_DEF,
    parameter int FIFO_DEPTH = `SLMI_FIFO_D_DEF
) (
    input  wire logic                     clk_sys,       // 250 MHz clock
    input  wire logic                     rst_b,         // async reset, low active
    input  wire logic                     ce,            // clock enable
    input  wire logic                     s_axi_awvalid, // write address valid
    output logic                          s_axi_awready, // write address ready
    input  wire logic [`SLMI_ADDR_W-1:0]  s_axi_awaddr,  // write byte address
    input  wire logic [2:0]               s_axi_awprot,  // unused
    input  wire logic                     s_axi_wvalid,  // write data valid
    output logic                          s_axi_wready,  // write data ready
    input  wire logic [31:0]              s_axi_wdata,   // write data
    input  wire logic [3:0]               s_axi_wstrb,   // byte enables
    output logic                          s_axi_bvalid,  // write response valid
    input  wire logic                     s_axi_bready,  // write response ready
    output logic [1:0]                    s_axi_bresp,   // write response
    input  wire logic                     s_axi_arvalid, // read address valid
    output logic                          s_axi_arready, // read address ready
    input  wire logic [`SLMI_ADDR_W-1:0]  s_axi_araddr,  // read byte address
    input  wire logic [2:0]               s_axi_arprot,  // unused
    output logic                          s_axi_rvalid,  // read data valid
    input  wire logic                     s_axi_rready,  // read data ready
    output logic [31:0]                   s_axi_rdata,   // read data
    output logic [1:0]                    s_axi_rresp,   // read response
    input  wire logic                     log_valid,     // logical lane word valid
    output logic                          log_ready,     // FIFO has room
    input  wire logic [`SLMI_LOG_LANES*LANE_W-1:0] log_data, // lanes 7..0
    output logic                          phys_valid,    // physical word valid
    input  wire logic                     phys_ready,    // link side takes it
    output logic [LANE_W-1:0]             phys_out_lane_four,  // lane 4
    output logic [LANE_W-1:0]             phys_out_lane_five,  // lane 5
    output logic [LANE_W-1:0]             phys_out_lane_six,   // lane 6
    output logic [LANE_W-1:0]             phys_out_lane_seven  // lane 7
);
    localparam int FW = `SLMI_LOG_LANES * LANE_W;

    // elaboration check
    if (LANE_W < 1 || FIFO_DEPTH < 2) begin : g_bad
        $error("slmi_top: LANE_W must be at least 1 and FIFO_DEPTH at least 2");
    end

    typedef struct packed {
        slmi_regs_t                                   regs;
        slmi_bus_t                                    bus;
        logic                                         out_valid;
        logic [`SLMI_PHYS_LANES-1:0][LANE_W-1:0]      out_lanes;
    } slmi_top_st_t;

    slmi_top_st_t q;
    slmi_top_st_t d;

    logic                                        f_valid;
    logic                                        f_ready;
    logic [FW-1:0]                               f_data;
    logic [`SLMI_LOG_LANES-1:0][LANE_W-1:0]      f_lanes;
    logic [`SLMI_PHYS_LANES-1:0][`SLMI_F_W-1:0]  sel;
    logic [`SLMI_PHYS_LANES-1:0][LANE_W-1:0]     raw;
    logic [`SLMI_PHYS_LANES-1:0][LANE_W-1:0]     mapped;
    logic                                        load;
    logic                                        aw_hs;
    logic                                        w_hs;
    logic                                        ar_hs;
    logic [`SLMI_IDX_W-1:0]                      ar_idx;
    logic [`SLMI_ADDR_W-`SLMI_IDX_W-3:0]         unused_hi;

    // input buffer; its ready reaches the lane source
    slmi_fifo #(
        .W     (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .ce        (ce),
        .in_valid  (log_valid),
        .in_ready  (log_ready),
        .in_data   (log_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    assign f_lanes = f_data;

    // selection fields per physical lane
    assign sel[0] = q.regs.lane_map_middle_pair[`SLMI_F_LO_LSB +: `SLMI_F_W];
    assign sel[1] = q.regs.lane_map_middle_pair[`SLMI_F_HI_LSB +: `SLMI_F_W];
    assign sel[2] = q.regs.lane_map_upper_pair[`SLMI_F_LO_LSB +: `SLMI_F_W];
    assign sel[3] = q.regs.lane_map_upper_pair[`SLMI_F_HI_LSB +: `SLMI_F_W];

    // per physical lane: pick the logical lane, then optionally invert
    for (genvar g = 0; g < `SLMI_PHYS_LANES; g++) begin : g_lane
        assign raw[g]    = f_lanes[sel[g]];
        assign mapped[g] = raw[g] ^ {LANE_W{q.regs.lane_polarity_invert[`SLMI_INV_BASE + g]}};
    end

    // handshakes; valids drop while the enable is low so no transfer is missed
    assign s_axi_awready = ce && !q.bus.aw_have;
    assign s_axi_wready  = ce && !q.bus.w_have;
    assign s_axi_arready = ce && !q.bus.rvalid;
    assign s_axi_bvalid  = ce && q.bus.bvalid;
    assign s_axi_rvalid  = ce && q.bus.rvalid;
    assign s_axi_bresp   = q.bus.bresp;
    assign s_axi_rresp   = q.bus.rresp;
    assign s_axi_rdata   = {24'h000000, q.bus.rbyte};
    assign aw_hs         = s_axi_awvalid && s_axi_awready;
    assign w_hs          = s_axi_wvalid && s_axi_wready;
    assign ar_hs         = s_axi_arvalid && s_axi_arready;
    assign ar_idx        = s_axi_araddr[2 +: `SLMI_IDX_W];
    assign unused_hi     = s_axi_araddr[`SLMI_ADDR_W-1 -: `SLMI_ADDR_W-`SLMI_IDX_W-2];

    // output stage refills when empty or drained
    assign f_ready    = ce && (!q.out_valid || phys_ready);
    assign load       = f_valid && f_ready;
    assign phys_valid = ce && q.out_valid;
    assign phys_out_lane_four  = q.out_lanes[0];
    assign phys_out_lane_five  = q.out_lanes[1];
    assign phys_out_lane_six   = q.out_lanes[2];
    assign phys_out_lane_seven = q.out_lanes[3];

    // next state: register writes, reads and the lane stage
    always_comb begin
        d = q;
        if (aw_hs) begin
            d.bus.aw_have = 1'b1;
            d.bus.aw_idx  = s_axi_awaddr[2 +: `SLMI_IDX_W];
        end
        if (w_hs) begin
            d.bus.w_have  = 1'b1;
            d.bus.w_byte  = s_axi_wdata[7:0];
            d.bus.w_strb0 = s_axi_wstrb[0];
        end
        if (ce && q.bus.aw_have && q.bus.w_have && !q.bus.bvalid) begin
            d.bus.aw_have = 1'b0;
            d.bus.w_have  = 1'b0;
            d.bus.bvalid  = 1'b1;
            d.bus.bresp   = `SLMI_RESP_OKAY;
            case (q.bus.aw_idx)
                `SLMI_IDX_MAP_MID: begin
                    if (q.bus.w_strb0) begin
                        d.regs.lane_map_middle_pair = q.bus.w_byte & `SLMI_MAP_MASK;
                    end
                end
                `SLMI_IDX_MAP_UP: begin
                    if (q.bus.w_strb0) begin
                        d.regs.lane_map_upper_pair = q.bus.w_byte & `SLMI_MAP_MASK;
                    end
                end
                `SLMI_IDX_INVERT: begin
                    if (q.bus.w_strb0) begin
                        d.regs.lane_polarity_invert = q.bus.w_byte;
                    end
                end
                default: begin
                    d.bus.bresp = `SLMI_RESP_DECERR;
                end
            endcase
        end else if (ce && q.bus.bvalid && s_axi_bready) begin
            d.bus.bvalid = 1'b0;
        end
        if (ar_hs) begin
            d.bus.rvalid   = 1'b1;
            d.bus.rresp    = `SLMI_RESP_OKAY;
            d.bus.r_is_map = 1'b0;
            case (ar_idx)
                `SLMI_IDX_MAP_MID: begin
                    d.bus.rbyte    = q.regs.lane_map_middle_pair & `SLMI_MAP_MASK;
                    d.bus.r_is_map = 1'b1;
                end
                `SLMI_IDX_MAP_UP: begin
                    d.bus.rbyte    = q.regs.lane_map_upper_pair & `SLMI_MAP_MASK;
                    d.bus.r_is_map = 1'b1;
                end
                `SLMI_IDX_INVERT: begin
                    d.bus.rbyte = q.regs.lane_polarity_invert;
                end
                default: begin
                    d.bus.rbyte = 8'h00;
                    d.bus.rresp = `SLMI_RESP_DECERR;
                end
            endcase
        end else if (ce && q.bus.rvalid && s_axi_rready) begin
            d.bus.rvalid = 1'b0;
        end
        if (load) begin
            d.out_valid = 1'b1;
            d.out_lanes = mapped;
        end else if (ce && q.out_valid && phys_ready) begin
            d.out_valid = 1'b0;
        end
    end

    // state register with reset to the identity map
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q                           <= '0;
            q.regs.lane_map_middle_pair <= `SLMI_RST_MAP_MID;
            q.regs.lane_map_upper_pair  <= `SLMI_RST_MAP_UP;
            q.regs.lane_polarity_invert <= `SLMI_RST_INVERT;
        end else if (ce) begin
            q <= d;
        end
    end

    // checks on mapping, inversion and reserved bits
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // selections read straight from the register fields
    logic [`SLMI_F_W-1:0] exp_sel4;
    logic [`SLMI_F_W-1:0] exp_sel6;
    logic [`SLMI_F_W-1:0] exp_sel7;
    assign exp_sel4 = q.regs.lane_map_middle_pair[`SLMI_F_LO_LSB +: `SLMI_F_W];
    assign exp_sel6 = q.regs.lane_map_upper_pair[`SLMI_F_LO_LSB +: `SLMI_F_W];
    assign exp_sel7 = q.regs.lane_map_upper_pair[`SLMI_F_HI_LSB +: `SLMI_F_W];

    // a write of all ones to the upper map register is committed
    sequence s_wr_up_ones;
        ce && q.bus.aw_have && q.bus.w_have && !q.bus.bvalid && q.bus.w_strb0
            && q.bus.aw_idx == `SLMI_IDX_MAP_UP && q.bus.w_byte == 8'hff;
    endsequence

    // a held address and data pair is committed
    sequence s_wr_taken;
        ce && q.bus.aw_have && q.bus.w_have && !q.bus.bvalid;
    endsequence

    // a held pair aimed at no register is committed
    sequence s_wr_unmapped;
        ce && q.bus.aw_have && q.bus.w_have && !q.bus.bvalid
            && q.bus.aw_idx != `SLMI_IDX_MAP_MID
            && q.bus.aw_idx != `SLMI_IDX_MAP_UP
            && q.bus.aw_idx != `SLMI_IDX_INVERT;
    endsequence

    // mapped lanes carry the selected logical lane, inverted on request
    AST_LANE7_MAP: assert property (load |=>
        phys_out_lane_seven == ($past(f_lanes[exp_sel7])
            ^ {LANE_W{$past(q.regs.lane_polarity_invert[7])}}))
        else $error("lane 7 mismatch");
    AST_LANE6_MAP: assert property (load |=>
        phys_out_lane_six == ($past(f_lanes[exp_sel6])
            ^ {LANE_W{$past(q.regs.lane_polarity_invert[6])}}))
        else $error("lane 6 mismatch");
    AST_LANE4_MAP: assert property (load && !q.regs.lane_polarity_invert[4] |=>
        phys_out_lane_four == $past(f_lanes[exp_sel4]))
        else $error("lane 4 mismatch");
    AST_SEL_INDEX: assert property (load && exp_sel7 == 3'h0 |=>
        phys_out_lane_seven == ($past(f_lanes[0])
            ^ {LANE_W{$past(q.regs.lane_polarity_invert[7])}}))
        else $error("index decode wrong");
    AST_INVERT4: assert property (load && q.regs.lane_polarity_invert[4] |=>
        phys_out_lane_four == ~$past(f_lanes[exp_sel4]))
        else $error("lane 4 not inverted");

    // reset values and reserved bits
    AST_RST_VALUES: assert property ($rose(rst_b) |->
        q.regs.lane_map_middle_pair == `SLMI_RST_MAP_MID
            && q.regs.lane_map_upper_pair == `SLMI_RST_MAP_UP
            && q.regs.lane_polarity_invert == `SLMI_RST_INVERT)
        else $error("reset values wrong");
    AST_RSVD_KEPT: assert property (
        (q.regs.lane_map_middle_pair & ~`SLMI_MAP_MASK) == 8'h00
            && (q.regs.lane_map_upper_pair & ~`SLMI_MAP_MASK) == 8'h00) else $error("reserved bits set");
    AST_RSVD_WRITE: assert property (s_wr_up_ones |=>
        q.regs.lane_map_upper_pair == `SLMI_MAP_MASK)
        else $error("reserved bits written");
    AST_RSVD_READ: assert property (s_axi_rvalid && q.bus.r_is_map |->
        s_axi_rdata[7] == 1'b0 && s_axi_rdata[3] == 1'b0)
        else $error("reserved bits read nonzero");

    // bus answers and the output hold
    AST_BRESP: assert property (s_wr_taken |=>
        q.bus.bvalid ##0 !q.bus.aw_have)
        else $error("write response missing");
    AST_UNMAPPED: assert property (s_wr_unmapped |=>
        $stable(q.regs) && q.bus.bresp == `SLMI_RESP_DECERR)
        else $error("unmapped write changed a register");
    AST_RD_INVERT: assert property (ar_hs && ar_idx == `SLMI_IDX_INVERT |=>
        s_axi_rdata[7:0] == $past(q.regs.lane_polarity_invert))
        else $error("invert register read back wrong");
    AST_OUT_HOLD: assert property (phys_valid && !phys_ready |=>
        !ce || (phys_valid && $stable(phys_out_lane_four) && $stable(phys_out_lane_seven)))
        else $error("stalled lane word changed");

endmodule : slmi_top

//--- verif/slmi_link_rx.sv
// link receiver stand-in: takes physical lane words and records them
// assumes the block's stream outputs, one clock and an async low reset
`timescale 1ns/1ps

module slmi_link_rx #(
    parameter int LW = 8
) (
    input  wire logic          clk_sys,    // system clock
    input  wire logic          rst_b,      // async reset, low active
    input  wire logic          stall,      // bench holds the receiver off
    input  wire logic          slow,       // accept only every other cycle
    input  wire logic          phys_valid, // word offered
    output logic               phys_ready, // receiver takes it
    input  wire logic [LW-1:0] lane4,      // physical lane 4
    input  wire logic [LW-1:0] lane5,      // physical lane 5
    input  wire logic [LW-1:0] lane6,      // physical lane 6
    input  wire logic [LW-1:0] lane7       // physical lane 7
);
    logic [4*LW-1:0] got[$]; // received words, lane 7 on top
    logic            tog_q;  // pacing toggle for slow mode

    // pace ready after each edge and record every word taken
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phys_ready <= 1'b0;
            tog_q <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            phys_ready <= !stall && !(slow && tog_q);
            if (phys_valid && phys_ready) got.push_back({lane7, lane6, lane5, lane4});
        end
    end
endmodule : slmi_link_rx

//--- verif/tb.sv
// self-checking bench for the lane map and polarity invert block
// assumes slmi_defs.svh on the include path and the receiver model beside it
`timescale 1ns/1ps
`include "slmi_defs.svh"

module tb import slmi_pkg::*; ;
    localparam int LW = 8;
    localparam logic [15:0] A_MID = 16'({`SLMI_IDX_MAP_MID, 2'b00});
    localparam logic [15:0] A_UP  = 16'({`SLMI_IDX_MAP_UP, 2'b00});
    localparam logic [15:0] A_INV = 16'({`SLMI_IDX_INVERT, 2'b00});
    localparam logic [15:0] A_BAD = 16'h16dc; // unmapped word between maps and invert
    localparam logic [63:0] W0    = 64'h8877665544332211;
    logic clk_sys = 1'b0, rst_b = 1'b0, ce = 1'b1, stall = 1'b0, slow = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, log_valid = 1'b0;
    logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [8*LW-1:0] log_data = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic log_ready, phys_valid, phys_ready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [LW-1:0] phys_out_lane_four, phys_out_lane_five, phys_out_lane_six, phys_out_lane_seven;
    logic [7:0] cur_mid, cur_up, cur_inv; // register contents the bench expects
    int failures = 0, comparisons = 0;

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    slmi_top #(.LANE_W(LW), .FIFO_DEPTH(4)) dut (.clk_sys, .rst_b, .ce, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .log_valid, .log_ready, .log_data,
        .phys_valid, .phys_ready, .phys_out_lane_four, .phys_out_lane_five,
        .phys_out_lane_six, .phys_out_lane_seven);

    slmi_link_rx #(.LW(LW)) rx (.clk_sys, .rst_b, .stall, .slow, .phys_valid, .phys_ready,
        .lane4(phys_out_lane_four), .lane5(phys_out_lane_five),
        .lane6(phys_out_lane_six), .lane7(phys_out_lane_seven));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // one AXI4-Lite write of the low byte, checking the response code
    task automatic axi_wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp} | 32'(n >= 200) << 8, {30'h0, er}, "write response");
        @(posedge clk_sys);
    endtask : axi_wr

    // one AXI4-Lite read, checking data and response code
    task automatic axi_rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata | 32'(n >= 200) << 8, ed, "read data");
        chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
        @(posedge clk_sys);
    endtask : axi_rd

    // expected lanes 7..4 from the map fields and invert bits
    function automatic logic [31:0] map_exp(input logic [63:0] d, input logic [7:0] m,
                                            input logic [7:0] u, input logic [7:0] v);
        logic [2:0] s [4];
        s = '{m[2:0], m[6:4], u[2:0], u[6:4]};
        for (int p = 0; p < 4; p++)
            map_exp[p*8 +: 8] = d[s[p]*8 +: 8] ^ {8{v[p+4]}};
    endfunction : map_exp

    task automatic send(input logic [63:0] d);
        int n;
        n = 0;
        log_data <= d;
        log_valid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!log_ready && n < 200);
        log_valid <= 1'b0;
        chk(32'(n >= 200), 32'h0, "input word taken");
        @(posedge clk_sys);
    endtask : send

    task automatic rx_chk(input logic [31:0] e);
        int n;
        n = 0;
        while (rx.got.size() == 0 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        chk(rx.got.size() > 0 ? rx.got.pop_front() : 32'hxxxxxxxx, e, "lane word");
    endtask : rx_chk

    task automatic t_reset();
        axi_rd(A_MID, 32'h54, 2'h0);
        axi_rd(A_UP, 32'h76, 2'h0);
        axi_rd(A_INV, 32'h00, 2'h0);
        axi_rd(A_BAD, 32'h00, 2'h3);
        send(W0);
        rx_chk(32'h88776655);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_reserved();
        axi_wr(A_MID, 8'hff, 2'h0);
        axi_rd(A_MID, 32'h77, 2'h0);
        axi_wr(A_UP, 8'hff, 2'h0);
        axi_rd(A_UP, 32'h77, 2'h0);
        axi_wr(A_UP, 8'h88, 2'h0);
        axi_rd(A_UP, 32'h00, 2'h0);
        axi_wr(A_INV, 8'hf0, 2'h0);
        axi_rd(A_INV, 32'hf0, 2'h0);
        axi_wr(A_BAD, 8'h12, 2'h3);
        send(W0);
        rx_chk(map_exp(W0, 8'h77, 8'h00, 8'hf0));
        $display("test reserved bits done");
    endtask : t_reserved

    task automatic t_map();
        logic [2:0] s;
        for (int i = 0; i < 8; i++) begin
            s = 3'(i);
            cur_mid = {1'b0, s, 1'b0, ~s};
            cur_up = {1'b0, s + 3'h3, 1'b0, s + 3'h5};
            cur_inv = {s[0], s[1], s[2], ~s[0], 4'h5};
            slow <= s[0];
            axi_wr(A_MID, cur_mid, 2'h0);
            axi_wr(A_UP, cur_up, 2'h0);
            axi_wr(A_INV, cur_inv, 2'h0);
            send(W0 ^ {8{8'(i * 16)}});
            rx_chk(map_exp(W0 ^ {8{8'(i * 16)}}, cur_mid, cur_up, cur_inv));
        end
        slow <= 1'b0;
        $display("test lane selection done");
    endtask : t_map

    task automatic t_fill();
        int acc;
        acc = 0;
        stall <= 1'b1;
        log_valid <= 1'b1;
        log_data <= W0;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (log_ready) begin
                acc++;
                log_data <= W0 ^ {8{8'(acc)}};
            end
        end
        stall <= 1'b0;
        chk(32'(acc), 32'd5, "words taken while stalled"); // four buffered plus output stage
        // the word still on offer goes in once the receiver drains
        do @(posedge clk_sys); while (!log_ready);
        log_valid <= 1'b0;
        for (int i = 0; i <= acc; i++)
            rx_chk(map_exp(W0 ^ {8{8'(i)}}, cur_mid, cur_up, cur_inv));
        $display("test buffer fill done");
    endtask : t_fill

    // clock enable low: nothing taken, the held word goes in once released
    task automatic t_freeze();
        ce <= 1'b0;
        log_data <= W0;
        log_valid <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({31'h0, log_ready}, 32'h0, "input ready while frozen");
        ce <= 1'b1;
        do @(posedge clk_sys); while (!log_ready);
        log_valid <= 1'b0;
        rx_chk(map_exp(W0, cur_mid, cur_up, cur_inv));
        $display("test clock enable done");
    endtask : t_freeze

    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // reset, then the scenarios in turn
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_reserved();
        t_map();
        t_fill();
        t_freeze();
        tally_and_finish();
    end

    // watchdog well beyond the expected run
    initial begin
        #(20000 * 4);
        failures++;
        tally_and_finish();
    end
endmodule : tb
